// [design/sbd_bridge.sv]
// Primary to secondary bridge with internal SRAM, decoding and ready.
`include "sbd_map.svh"
`default_nettype none
module sbd_bridge #(
   parameter int EXT_WAIT_CYCLES = `SBD_EXT_WAIT
) (
   input  wire logic                         clk_i,          // Processor clock
   input  wire logic                         nrst_i,         // Reset, async low
   input  wire logic [`SBD_ADDR_W-1:0]       primary_addr_i, // Primary address
   input  wire logic [`SBD_DATA_W-1:0]       pri_data_i,     // Primary data in
   output logic      [`SBD_DATA_W-1:0]       pri_data_o,     // Primary data out
   output logic                              pri_data_oe_o,  // Primary data drive
   input  wire logic                         rw_i,           // High read, low write
   input  wire logic                         data_space_select_n_i,    // Low
   input  wire logic                         program_space_select_n_i, // Low
   input  wire logic                         io_space_select_n_i,      // Low
   input  wire logic                         memory_strobe_n_i,        // Low
   input  wire logic                         io_strobe_n_i,            // Low
   input  wire logic                         primary_sram_select_n_i,  // Low
   input  wire logic                         transceiver_control_n_i,  // Low
   input  wire logic                         narrow_addr_i,  // 16-bit address mode
   input  wire logic                         only_non_sram_i,// Filter SRAM cycles
   input  wire logic                         cfg_load_i,     // Load decode register
   input  wire logic [2:0]                   cfg_index_i,    // Register number
   input  wire logic [`SBD_CFG_W-1:0]        cfg_word_i,     // Register value
   output logic      [`SBD_CFG_W-1:0]        cfg_word_o,     // Readback of index
   output logic                              sram_cycle_o,   // SRAM cycle seen
   output logic                              ready_o,        // Ready, high
   output logic      [`SBD_NUM_CS-1:0]       external_chip_select_n_o, // Low
   output logic      [`SBD_SEC_ADDR_W-1:0]   sec_addr_o,     // Secondary address
   output logic      [`SBD_DATA_W-1:0]       sec_data_o,     // Secondary data out
   output logic                              sec_data_oe_o,  // Secondary drive
   input  wire logic [`SBD_DATA_W-1:0]       sec_data_i,     // Secondary data in
   output logic                              sec_rw_o,       // Secondary direction
   output logic                              sec_data_space_select_n_o,    // Data space copy
   output logic                              sec_program_space_select_n_o, // Program space copy
   output logic                              sec_io_space_select_n_o,      // I/O space copy
   output logic                              sec_memory_strobe_n_o,        // Memory strobe copy
   output logic                              sec_io_strobe_n_o             // I/O strobe copy
);
   import sbd_pkg::*;
   localparam int EXT_W = EXT_WAIT_CYCLES;
   // ------------------------------------------------------------
   // Decode registers
   // ------------------------------------------------------------
   logic [`SBD_CFG_W-1:0]              cfg_reg  [`SBD_NUM_DEC];
   logic [`SBD_CFG_W-1:0]              cfg_next [`SBD_NUM_DEC];
   logic [`SBD_NUM_DEC*`SBD_CFG_W-1:0] cfg_flat;
   logic [`SBD_CFG_W-1:0]              rb_reg;
   logic [`SBD_CFG_W-1:0]              rb_next;
   genvar g;
   generate
      for (g = 0; g < `SBD_NUM_DEC; g++) begin : g_cfg
         always_comb begin
            cfg_next[g] = cfg_reg[g];
            if (cfg_load_i && cfg_index_i == 3'(g)) begin
               cfg_next[g] = cfg_word_i;
            end
         end
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               cfg_reg[g] <= `SBD_RST_CFG;
            end else begin
               cfg_reg[g] <= cfg_next[g];
            end
         end
         assign cfg_flat[g*`SBD_CFG_W +: `SBD_CFG_W] = cfg_reg[g];
      end
   endgenerate
   always_comb begin
      rb_next = '0;
      if (cfg_index_i < 3'(`SBD_NUM_DEC)) begin
         rb_next = cfg_reg[cfg_index_i];
      end
   end
   // ------------------------------------------------------------
   // Decoding and memory
   // ------------------------------------------------------------
   logic                   cycle_q;
   logic                   sram_hit;
   logic [`SBD_IDX_W-1:0]  sram_idx;
   logic [`SBD_DATA_W-1:0] sram_rd;
   logic                   sram_wr;
   sbd_decoder u_dec (
      .clk_i      (clk_i),
      .nrst_i     (nrst_i),
      .addr_i     (primary_addr_i),
      .data_space_select_n_i    (data_space_select_n_i),
      .program_space_select_n_i (program_space_select_n_i),
      .io_space_select_n_i      (io_space_select_n_i),
      .memory_strobe_n_i        (memory_strobe_n_i),
      .io_strobe_n_i            (io_strobe_n_i),
      .force_n_i  (primary_sram_select_n_i),
      .narrow_i   (narrow_addr_i),
      .cfg_i      (cfg_flat),
      .cycle_o    (cycle_q),
      .sram_hit_o (sram_hit),
      .sram_idx_o (sram_idx),
      .cs_n_o     (external_chip_select_n_o)
   );
   // The array is written once per cycle, on the first edge of the access.
   sbd_sram u_mem (
      .clk_i   (clk_i),
      .wr_i    (sram_wr),
      .idx_i   (sram_idx),
      .wdata_i (pri_data_i),
      .rdata_o (sram_rd)
   );
   // ------------------------------------------------------------
   // Ready generation
   // ------------------------------------------------------------
   sbd_state_t st_reg;
   sbd_state_t st_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        rdy_reg;
   logic        rdy_next;
   logic        srs_reg;
   logic        srs_next;
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      rdy_next = rdy_reg;
      srs_next = srs_reg;
      sram_wr  = 1'b0;
      case (st_reg)
         SBD_ST_IDLE: begin
            rdy_next = 1'b0;
            if (cycle_q) begin
               srs_next = sram_hit;
               if (sram_hit) begin
                  sram_wr  = !rw_i;
                  st_next  = SBD_ST_DONE;
                  rdy_next = 1'b1;
               end else begin
                  st_next  = SBD_ST_WAIT;
                  cnt_next = 16'(EXT_W - 1);
               end
            end
         end
         SBD_ST_WAIT: begin
            if (cnt_reg == 16'h0000) begin
               st_next  = SBD_ST_DONE;
               rdy_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 16'h0001;
            end
         end
         SBD_ST_DONE: begin
            if (!cycle_q) begin
               st_next  = SBD_ST_IDLE;
               rdy_next = 1'b0;
               srs_next = 1'b0;
            end
         end
         default: begin
            st_next  = SBD_ST_IDLE;
            rdy_next = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg  <= SBD_ST_IDLE;
         cnt_reg <= 16'h0000;
         rdy_reg <= 1'b0;
         srs_reg <= 1'b0;
         rb_reg  <= '0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
         srs_reg <= srs_next;
         rb_reg  <= rb_next;
      end
   end
   // ------------------------------------------------------------
   // Data paths and secondary rebroadcast
   // ------------------------------------------------------------
   logic [`SBD_DATA_W-1:0]     pd_reg, pd_next;
   logic                       poe_reg, poe_next;
   logic [`SBD_SEC_ADDR_W-1:0] sa_reg, sa_next;
   logic [`SBD_DATA_W-1:0]     sd_reg, sd_next;
   logic                       soe_reg, soe_next;
   logic [5:0]                 sc_reg, sc_next;
   logic                       block;
   always_comb begin
      block    = only_non_sram_i && sram_hit;
      pd_next  = pri_data_i;
      poe_next = 1'b0;
      if (cycle_q && rw_i && sram_hit) begin
         pd_next  = sram_rd;
         poe_next = 1'b1;
      end else if (rw_i && !transceiver_control_n_i) begin
         pd_next  = sec_data_i;
         poe_next = 1'b1;
      end
      sa_next  = primary_addr_i[`SBD_SEC_ADDR_W-1:0];
      sd_next  = pri_data_i;
      soe_next = !rw_i && !block;
      sc_next  = {rw_i,
                  data_space_select_n_i    || block,
                  program_space_select_n_i || block,
                  io_space_select_n_i,
                  memory_strobe_n_i        || block,
                  io_strobe_n_i};
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pd_reg  <= '0;
         poe_reg <= 1'b0;
         sa_reg  <= '0;
         sd_reg  <= '0;
         soe_reg <= 1'b0;
         sc_reg  <= 6'h3f;
      end else begin
         pd_reg  <= pd_next;
         poe_reg <= poe_next;
         sa_reg  <= sa_next;
         sd_reg  <= sd_next;
         soe_reg <= soe_next;
         sc_reg  <= sc_next;
      end
   end
   assign pri_data_o     = pd_reg;
   assign pri_data_oe_o  = poe_reg;
   assign cfg_word_o     = rb_reg;
   assign sram_cycle_o   = srs_reg;
   assign ready_o        = rdy_reg;
   assign sec_addr_o     = sa_reg;
   assign sec_data_o     = sd_reg;
   assign sec_data_oe_o  = soe_reg;
   assign sec_rw_o       = sc_reg[5];
   assign sec_data_space_select_n_o    = sc_reg[4];
   assign sec_program_space_select_n_o = sc_reg[3];
   assign sec_io_space_select_n_o      = sc_reg[2];
   assign sec_memory_strobe_n_o        = sc_reg[1];
   assign sec_io_strobe_n_o            = sc_reg[0];
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_sram_start;
      st_reg == SBD_ST_IDLE && cycle_q && sram_hit;
   endsequence
   sequence s_ext_start;
      st_reg == SBD_ST_IDLE && cycle_q && !sram_hit;
   endsequence
   property p_sram_ready;
      @(posedge clk_i) disable iff (!nrst_i) s_sram_start |=> ready_o;
   endproperty
   a_sram_ready: assert property (p_sram_ready) else $error("SRAM ready late");
   property p_ext_ready;
      @(posedge clk_i) disable iff (!nrst_i) s_ext_start |=> !ready_o ##EXT_W ready_o;
   endproperty
   a_ext_ready: assert property (p_ext_ready) else $error("External ready timing");
   property p_rw_copy;
      @(posedge clk_i) disable iff (!nrst_i) 1'b1 |=> sec_rw_o == $past(rw_i);
   endproperty
   a_rw_copy: assert property (p_rw_copy) else $error("Direction not repeated");
   property p_repeat;
      @(posedge clk_i) disable iff (!nrst_i)
         !only_non_sram_i |=> sec_memory_strobe_n_o == $past(memory_strobe_n_i)
                              && sec_addr_o == $past(primary_addr_i[15:0]);
   endproperty
   a_repeat: assert property (p_repeat) else $error("Cycle not rebroadcast");
   property p_filter;
      @(posedge clk_i) disable iff (!nrst_i)
         (only_non_sram_i && sram_hit) |=> sec_memory_strobe_n_o && !sec_data_oe_o;
   endproperty
   a_filter: assert property (p_filter) else $error("SRAM cycle leaked");
   property p_sram_read;
      @(posedge clk_i) disable iff (!nrst_i)
         (cycle_q && sram_hit && rw_i) |=> pri_data_oe_o && pri_data_o == $past(sram_rd);
   endproperty
   a_sram_read: assert property (p_sram_read) else $error("SRAM read data wrong");
   property p_transceiver;
      @(posedge clk_i) disable iff (!nrst_i)
         (!transceiver_control_n_i && rw_i && !(cycle_q && sram_hit))
         |=> pri_data_oe_o && pri_data_o == $past(sec_data_i);
   endproperty
   a_transceiver: assert property (p_transceiver) else $error("Transceiver path broken");
endmodule : sbd_bridge
`default_nettype wire

// [pkg/sbd_map.svh]
// Constants of the bridge with internal SRAM and space decoder.
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
`define SBD_ADDR_W     22
`define SBD_DATA_W     16
`define SBD_SEC_ADDR_W 16
`define SBD_MEM_DEPTH  65536
`define SBD_IDX_W      16
`define SBD_NUM_DEC    6
`define SBD_NUM_CS     6
`define SBD_CFG_W      24
`define SBD_EXT_WAIT   3
// Decode register 0 fields, one group per 32K-word region.
`define SBD_R0_EN0     0
`define SBD_R0_PRG0    1
`define SBD_R0_BASE0   2
`define SBD_R0_EN1     9
`define SBD_R0_PRG1    10
`define SBD_R0_BASE1   11
`define SBD_R0_BASE_W  7
// Decode register 1 to 5 fields.
`define SBD_RX_EN      0
`define SBD_RX_SPACE   1
`define SBD_RX_BASE    3
`define SBD_RX_LIMIT   12
`define SBD_RX_CS      21
`define SBD_BLK_W      9
`define SBD_CS_W       3
`define SBD_RST_CFG    24'h000000
`endif

// [pkg/sbd_pkg.sv]
// Types shared by the bridge modules.
`default_nettype none
package sbd_pkg;
   typedef enum logic [1:0] {
      SBD_SP_DATA = 2'h0,
      SBD_SP_PROG = 2'h1,
      SBD_SP_IO   = 2'h2,
      SBD_SP_NONE = 2'h3
   } sbd_space_t;
   typedef enum logic [2:0] {
      SBD_ST_IDLE = 3'h1,
      SBD_ST_WAIT = 3'h2,
      SBD_ST_DONE = 3'h4
   } sbd_state_t;
endpackage : sbd_pkg
`default_nettype wire

// [design/sbd_sram.sv]
// Internal SRAM array held in flip-flops.
`include "sbd_map.svh"
`default_nettype none
module sbd_sram #(
   parameter int DEPTH = `SBD_MEM_DEPTH,
   parameter int WIDTH = `SBD_DATA_W,
   parameter int IDX_W = `SBD_IDX_W
) (
   input  wire logic             clk_i,   // Processor clock
   input  wire logic             wr_i,    // Write strobe, high
   input  wire logic [IDX_W-1:0] idx_i,   // Word index
   input  wire logic [WIDTH-1:0] wdata_i, // Write data
   output logic      [WIDTH-1:0] rdata_o  // Read data, combinational
);
   import sbd_pkg::*;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next;
   always_comb begin
      mem_next = wr_i ? wdata_i : mem_reg[idx_i];
   end
   // A write lands on the edge that starts the access, so no wait state is needed.
   always_ff @(posedge clk_i) begin
      mem_reg[idx_i] <= mem_next;
   end
   assign rdata_o = mem_reg[idx_i];
endmodule : sbd_sram
`default_nettype wire

// [design/sbd_decoder.sv]
// Space and address decoder for the internal SRAM and six chip selects.
`include "sbd_map.svh"
`default_nettype none
module sbd_decoder (
   input  wire logic                         clk_i,        // Clock for checks
   input  wire logic                         nrst_i,       // Reset, low
   input  wire logic [`SBD_ADDR_W-1:0]       addr_i,       // Primary address
   input  wire logic                         data_space_select_n_i,    // Data space, low
   input  wire logic                         program_space_select_n_i, // Program space, low
   input  wire logic                         io_space_select_n_i,      // I/O space, low
   input  wire logic                         memory_strobe_n_i,        // Memory strobe, low
   input  wire logic                         io_strobe_n_i,            // I/O strobe, low
   input  wire logic                         force_n_i,    // Primary SRAM select, low
   input  wire logic                         narrow_i,     // 16-bit address mode
   input  wire logic [`SBD_NUM_DEC*`SBD_CFG_W-1:0] cfg_i,  // Decode registers
   output logic                              cycle_o,      // Qualified cycle
   output logic                              sram_hit_o,   // SRAM selected
   output logic [`SBD_IDX_W-1:0]             sram_idx_o,   // SRAM word index
   output logic [`SBD_NUM_CS-1:0]            cs_n_o        // Chip selects, low
);
   import sbd_pkg::*;
   logic                      mem_q;
   logic                      io_q;
   logic                      dsel;
   logic                      psel;
   logic [`SBD_ADDR_W-1:0]    eff;
   logic [`SBD_BLK_W-1:0]     blk;
   logic [`SBD_CFG_W-1:0]     r0;
   logic [1:0]                reg_hit;
   logic [`SBD_NUM_DEC-2:0]   ext_hit;
   logic [`SBD_CS_W-1:0]      ext_cs;
   logic                      ext_any;
   always_comb begin
      dsel  = !data_space_select_n_i;
      psel  = !program_space_select_n_i;
      mem_q = (dsel || psel) && !memory_strobe_n_i;
      io_q  = !io_space_select_n_i && !io_strobe_n_i;
      eff   = narrow_i ? {6'h00, addr_i[15:0]} : addr_i;
      blk   = eff[`SBD_ADDR_W-1:13];
      r0    = cfg_i[`SBD_CFG_W-1:0];
   end
   // Each region answers one memory space only, never I/O.
   always_comb begin
      reg_hit[0] = r0[`SBD_R0_EN0] && mem_q
                   && (r0[`SBD_R0_PRG0] ? psel : dsel)
                   && eff[21:15] == r0[`SBD_R0_BASE0 +: `SBD_R0_BASE_W];
      reg_hit[1] = r0[`SBD_R0_EN1] && mem_q
                   && (r0[`SBD_R0_PRG1] ? psel : dsel)
                   && eff[21:15] == r0[`SBD_R0_BASE1 +: `SBD_R0_BASE_W];
      sram_hit_o = 1'b0;
      sram_idx_o = {1'b0, eff[14:0]};
      if (!force_n_i && mem_q) begin
         sram_hit_o = 1'b1;
         sram_idx_o = addr_i[15:0];
      end else if (reg_hit[0]) begin
         sram_hit_o = 1'b1;
      end else if (reg_hit[1]) begin
         sram_hit_o = 1'b1;
         sram_idx_o = {1'b1, eff[14:0]};
      end
   end
   genvar g;
   generate
      for (g = 1; g < `SBD_NUM_DEC; g++) begin : g_ext
         logic [`SBD_CFG_W-1:0] rx;
         logic                  sp_ok;
         sbd_space_t            sp;
         always_comb begin
            rx = cfg_i[g*`SBD_CFG_W +: `SBD_CFG_W];
            sp = sbd_space_t'(rx[`SBD_RX_SPACE +: 2]);
            case (sp)
               SBD_SP_DATA: sp_ok = mem_q && dsel;
               SBD_SP_PROG: sp_ok = mem_q && psel;
               SBD_SP_IO:   sp_ok = io_q;
               default:     sp_ok = 1'b0;
            endcase
            ext_hit[g-1] = rx[`SBD_RX_EN] && sp_ok
                           && blk >= rx[`SBD_RX_BASE +: `SBD_BLK_W]
                           && blk <= rx[`SBD_RX_LIMIT +: `SBD_BLK_W];
         end
      end
   endgenerate
   // The lowest-numbered matching decoder wins.
   always_comb begin
      ext_any = 1'b0;
      ext_cs  = '0;
      for (int i = `SBD_NUM_DEC - 2; i >= 0; i--) begin
         if (ext_hit[i]) begin
            ext_any = 1'b1;
            ext_cs  = cfg_i[(i+1)*`SBD_CFG_W + `SBD_RX_CS +: `SBD_CS_W];
         end
      end
      cycle_o = mem_q || io_q;
      cs_n_o  = '1;
      if (ext_any && !sram_hit_o && ext_cs < `SBD_CS_W'(`SBD_NUM_CS)) begin
         cs_n_o[ext_cs] = 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_io_no_sram;
      @(posedge clk_i) disable iff (!nrst_i) io_q |-> !sram_hit_o;
   endproperty
   a_io_no_sram: assert property (p_io_no_sram) else $error("I/O cycle hit SRAM");
   property p_one_cs;
      @(posedge clk_i) disable iff (!nrst_i) $onehot0(~cs_n_o);
   endproperty
   a_one_cs: assert property (p_one_cs) else $error("More than one chip select");
   property p_sram_no_cs;
      @(posedge clk_i) disable iff (!nrst_i) sram_hit_o |-> &cs_n_o;
   endproperty
   a_sram_no_cs: assert property (p_sram_no_cs) else $error("CS during SRAM cycle");
   property p_idle_quiet;
      @(posedge clk_i) disable iff (!nrst_i) !cycle_o |-> (&cs_n_o && !sram_hit_o);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("Select without strobe");
   property p_force;
      @(posedge clk_i) disable iff (!nrst_i)
         (!force_n_i && mem_q) |-> (sram_hit_o && sram_idx_o == addr_i[15:0]);
   endproperty
   a_force: assert property (p_force) else $error("Forced SRAM select ignored");
endmodule : sbd_decoder
`default_nettype wire

// [verification/sbd_sec_dev.sv]
// Secondary-bus device model answering reads under a chip select.
`default_nettype none
module sbd_sec_dev #(
   parameter logic [15:0] RDATA = 16'h5a3c
) (
   input  wire logic        clk_i,  // Processor clock
   input  wire logic [5:0]  cs_n_i, // Chip selects, low
   input  wire logic        rw_i,   // High read
   output logic      [15:0] data_o  // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q = 16'h0;
   assign data_o = q;
   // Unselected or writing, the bus inverts its previous value on every clock edge.
   always @(posedge clk_i) begin
      q <= (&cs_n_i || !rw_i) ? ~q : RDATA;
   end
endmodule : sbd_sec_dev
`default_nettype wire

// [verification/sbd_bridge_tb_top.sv]
// Self-checking testbench of the bridge.
`default_nettype none
module sbd_bridge_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EW = 2;
   logic clk_i = 1'b0, nrst_i = 1'b0, rw = 1'b1, ld = 1'b0, xc_n = 1'b1;
   logic dsel_n = 1'b1, psel_n = 1'b1, isel_n = 1'b1, ms_n = 1'b1, io_n = 1'b1;
   logic frc_n = 1'b1, nar = 1'b0, onl = 1'b0, poe, smsn, roe, rs, sms;
   logic [21:0] a = 22'h0;
   logic [15:0] wd = 16'h0, pd, sa, sdi, rd;
   logic [23:0] cw = 24'h0, cwo;
   logic [2:0] idx = 3'h0;
   logic [5:0] cs, csv;
   logic rdy, sc, srw;
   int n, n_errors = 0, n_compared = 0;
   always #12.5 clk_i = ~clk_i;
   sbd_sec_dev sbd_sec_dev_i (.clk_i(clk_i), .cs_n_i(cs), .rw_i(srw), .data_o(sdi));
   sbd_bridge #(.EXT_WAIT_CYCLES(EW)) sbd_bridge_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .primary_addr_i(a), .pri_data_i(wd), .pri_data_o(pd), .pri_data_oe_o(poe), .rw_i(rw),
      .data_space_select_n_i(dsel_n), .program_space_select_n_i(psel_n),
      .io_space_select_n_i(isel_n), .memory_strobe_n_i(ms_n), .io_strobe_n_i(io_n),
      .primary_sram_select_n_i(frc_n), .transceiver_control_n_i(xc_n),
      .narrow_addr_i(nar), .only_non_sram_i(onl), .cfg_load_i(ld), .cfg_index_i(idx),
      .cfg_word_i(cw), .cfg_word_o(cwo), .sram_cycle_o(sc), .ready_o(rdy),
      .external_chip_select_n_o(cs), .sec_addr_o(sa), .sec_data_o(), .sec_data_oe_o(),
      .sec_data_i(sdi), .sec_rw_o(srw), .sec_data_space_select_n_o(),
      .sec_program_space_select_n_o(), .sec_io_space_select_n_o(),
      .sec_memory_strobe_n_o(smsn), .sec_io_strobe_n_o());
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : chk
   task automatic cfg(input logic [2:0] i, input logic [23:0] w);
      @(negedge clk_i);
      ld = 1'b1; idx = i; cw = w;
      @(negedge clk_i);
      ld = 1'b0;
      @(negedge clk_i);
      chk(cwo, w, "readback");
   endtask : cfg
   // Runs one primary cycle and holds it until ready, as the master must.
   task automatic cyc(input logic [1:0] sp, input logic [21:0] ad, input logic r,
                      input logic [15:0] w);
      @(negedge clk_i);
      a = ad; rw = r; wd = w;
      dsel_n = sp != 2'h0; psel_n = sp != 2'h1; isel_n = sp != 2'h2;
      ms_n = sp == 2'h2; io_n = sp != 2'h2;
      #1 csv = cs;
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (rdy !== 1'b1 && n < 50);
      // Outputs that stand only for the ready cycle are captured here.
      rd = pd;
      roe = poe;
      rs = sc;
      sms = smsn;
      chk(sa, a[15:0], "sec addr");
      chk(srw, r, "sec rw");
      @(negedge clk_i);
      {dsel_n, psel_n, isel_n, ms_n, io_n} = 5'h1f;
      repeat (2) @(negedge clk_i);
   endtask : cyc
   task automatic t_sram;
      cfg(3'h0, 24'h000001);
      cyc(2'h0, 22'h000123, 1'b0, 16'hbeef);
      chk(24'(n), 24'h1, "write wait");
      chk(sms, 1'b0, "sec strobe");
      cyc(2'h0, 22'h000123, 1'b1, 16'h0);
      chk(24'(n), 24'h1, "read wait");
      chk(rd, 16'hbeef, "sram data");
      chk(roe, 1'b1, "primary drive");
      chk(rs, 1'b1, "sram cycle");
      $display("test sram done");
   endtask : t_sram
   task automatic t_io;
      cfg(3'h1, 24'h200005);
      xc_n = 1'b0;
      cyc(2'h2, 22'h000123, 1'b1, 16'h0);
      xc_n = 1'b1;
      chk(csv, 6'h3d, "io cs");
      chk(24'(n), 24'(EW + 1), "io wait");
      chk(rd, 16'h5a3c, "transceiver data");
      chk(rs, 1'b0, "io sram");
      $display("test io done");
   endtask : t_io
   task automatic t_unmapped;
      cyc(2'h0, 22'h008000, 1'b1, 16'h0);
      chk(csv, 6'h3f, "no cs");
      chk(rs, 1'b0, "no sram");
      chk(roe, 1'b0, "no drive");
      chk(24'(n), 24'(EW + 1), "ext wait");
      $display("test unmapped done");
   endtask : t_unmapped
   // Forced select, rebroadcast filter and the narrow address mode.
   task automatic t_modes;
      cfg(3'h0, 24'h000e01);
      frc_n = 1'b0;
      onl = 1'b1;
      cyc(2'h1, 22'h3f8123, 1'b0, 16'h1234);
      chk(24'(n), 24'h1, "forced wait");
      chk(rs, 1'b1, "forced sram");
      chk(sms, 1'b1, "filtered strobe");
      frc_n = 1'b1;
      nar = 1'b1;
      cyc(2'h1, 22'h3f8123, 1'b1, 16'h0);
      chk(rd, 16'h1234, "narrow region");
      chk(rs, 1'b1, "region hit");
      cyc(2'h0, 22'h008123, 1'b1, 16'h0);
      chk(rs, 1'b0, "space split");
      chk(24'(n), 24'(EW + 1), "split wait");
      $display("test modes done");
   endtask : t_modes
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      chk(rdy, 1'b0, "reset ready");
      t_sram();
      t_io();
      t_unmapped();
      t_modes();
      results();
   end
   initial begin
      #(25 * 3000);
      n_errors++;
      results();
   end
endmodule : sbd_bridge_tb_top
`default_nettype wire
